// >>> logic/ptm_map.vh
// Constants for the programmed I/O target: header fields, region codes, layout.
// Assumes 64-bit receive and transmit streams with the usual dword order.
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

// Region memory: 2 KB each, 32-bit words
`define PTM_RAM_AW 9
`define PTM_RAM_WORDS 512
`define PTM_ADDR_W 11

// Stream widths
`define PTM_DATA_W 64
`define PTM_KEEP_W 8
`define PTM_USER_W 22
`define PTM_USER_HIT_HI 9
`define PTM_USER_HIT_LO 2

// Hit vector patterns
`define PTM_HIT_IO 8'h01
`define PTM_HIT_MEM64 8'h02
`define PTM_HIT_MEM32 8'h04
`define PTM_HIT_EXPROM 8'h40

// Region codes
`define PTM_REG_IO 2'h0
`define PTM_REG_MEM32 2'h1
`define PTM_REG_MEM64 2'h2
`define PTM_REG_EXPROM 2'h3

// Format and type, {fmt[1:0], type[4:0]}
`define PTM_FT_MRD32 7'h00
`define PTM_FT_MRD64 7'h20
`define PTM_FT_MWR32 7'h40
`define PTM_FT_MWR64 7'h60
`define PTM_FT_IORD 7'h02
`define PTM_FT_IOWR 7'h42
`define PTM_FT_CPL 7'h0A
`define PTM_FT_CPLD 7'h4A

// Completion fields
`define PTM_CPL_SC 3'h0
`define PTM_LEN_ONE 10'h001
`define PTM_KEEP_ALL 8'hFF
`define PTM_KEEP_LO 8'h0F

`endif

// >>> logic/ptm_region_ram.v
// One 2 KB dual-port region memory: write port A, read port B.
// Assumes one clock; read data is registered, one cycle after the address.
module ptm_region_ram (
  // Clock
  input wire sys_clk,
  // Write port
  input wire wr_en,
  input wire [8:0] wr_addr,
  input wire [3:0] wr_be,
  input wire [31:0] wr_data,
  // Read port
  input wire [8:0] rd_addr,
  output reg [31:0] rd_data_q
);
  reg [31:0] mem_q [0:511];
  integer i;

  always @(posedge sys_clk) begin
    for (i = 0; i < 4; i = i + 1) begin
      if (wr_en && wr_be[i]) begin
        mem_q[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
      end
    end
    rd_data_q <= mem_q[rd_addr];
  end
endmodule

// >>> logic/ptm_target.v
// Target-only programmed I/O responder behind an endpoint core, 64-bit streams.
// Assumes core user clock and synchronous reset; requests pre-filtered by BARs.
// Notes on behaviour
// - Four 2 KB target regions, 8192 bytes of target space in all.
// - Each region has its own 2 KB dual-port memory.
// - Only 1-dword IO and 32/64-bit address memory reads and writes served.
// - Each valid memory or IO read returns a completion with one data dword.
// - IO writes get a successful completion without data; memory writes none.
// - A one-dword write stores its payload at the addressed region word.
// - Hit 0000_0100 picks mem32, 0000_0010 mem64, 0100_0000 expansion ROM.
// - Hit bit zero picks the IO region, off unless enabled by configuration.
// - At most one IO, one 32-bit memory and one 64-bit memory BAR.
// - Extra spaces of one type get no completion; only the first responds.
// - Apertures above 2 KB wrap onto the same 2 KB memory.
// - Memory requests longer than one dword are consumed and dropped silently.
// - On writes, address, data and region are taken before the write strobe.
// - Receive ready is held low while a memory write is in progress.
// - This is the 64-bit stream variant; it must match the core width.
// - Only completions are ever sent; no requests originate here.
// - Receive ready stays low until a read's completion has been generated.
`include "ptm_map.vh"

module ptm_target (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Receive stream from the core
  input wire [63:0] m_axis_rx_tdata,
  input wire [7:0] m_axis_rx_tkeep,
  input wire m_axis_rx_tlast,
  input wire m_axis_rx_tvalid,
  input wire [21:0] m_axis_rx_tuser,
  output reg m_axis_rx_tready_q,
  // Transmit stream to the core
  output reg [63:0] s_axis_tx_tdata_q,
  output reg [7:0] s_axis_tx_tkeep_q,
  output reg s_axis_tx_tlast_q,
  output reg s_axis_tx_tvalid_q,
  input wire s_axis_tx_tready,
  // Configuration
  input wire [15:0] cfg_completer_id,
  input wire io_bar_enable
);
  // Receive and completion sequencing states
  localparam ST_IDLE = 3'h0;
  localparam ST_HDR1 = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_DROP = 3'h3;
  localparam ST_WRITE = 3'h4;
  localparam ST_READ = 3'h5;
  localparam ST_CPL0 = 3'h6;
  localparam ST_CPL1 = 3'h7;

  // Request fields held until the next request's first beat is taken
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [6:0] ft_q;
  reg [2:0] tc_q;
  reg [1:0] attr_q;
  reg [15:0] rid_q;
  reg [7:0] tag_q;
  reg [3:0] be_q;
  reg [1:0] region_q;
  reg [`PTM_ADDR_W-1:0] addr_q;
  reg [31:0] wdata_q;

  // Decode of the first header beat
  wire [31:0] dw0 = m_axis_rx_tdata[31:0];
  wire [31:0] dw1 = m_axis_rx_tdata[63:32];
  wire [6:0] ft_in = dw0[30:24];
  wire [9:0] len_in = dw0[9:0];
  wire [7:0] hit = m_axis_rx_tuser[`PTM_USER_HIT_HI:`PTM_USER_HIT_LO];
  wire rx_acc = m_axis_rx_tvalid && m_axis_rx_tready_q;
  wire is_mem = (ft_in == `PTM_FT_MRD32) || (ft_in == `PTM_FT_MRD64) ||
                (ft_in == `PTM_FT_MWR32) || (ft_in == `PTM_FT_MWR64);
  wire is_io = (ft_in == `PTM_FT_IORD) || (ft_in == `PTM_FT_IOWR);
  wire is_wr = ft_in[6];

  // Region choice; any other hit pattern gets no answer
  // Exact patterns only: a second BAR of one type never answers
  reg hit_ok;
  reg [1:0] region_in;
  always @* begin
    hit_ok = 1'b1;
    region_in = `PTM_REG_MEM32;
    if (is_io && io_bar_enable && hit == `PTM_HIT_IO) begin
      region_in = `PTM_REG_IO;
    end else if (is_mem && hit == `PTM_HIT_MEM32) begin
      region_in = `PTM_REG_MEM32;
    end else if (is_mem && hit == `PTM_HIT_MEM64) begin
      region_in = `PTM_REG_MEM64;
    end else if (is_mem && hit == `PTM_HIT_EXPROM) begin
      region_in = `PTM_REG_EXPROM;
    end else begin
      hit_ok = 1'b0;
    end
  end

  // Accepted only for one-dword requests of a served type
  wire req_ok = (is_mem || is_io) && (len_in == `PTM_LEN_ONE) && hit_ok;

  // Two-entry transmit buffer; head drives the stream directly
  wire [72:0] push_word;
  wire push_v = (state_q == ST_CPL0) || (state_q == ST_CPL1);
  // Head register is the stream output itself
  reg [1:0] fifo_cnt_q;
  reg [72:0] fifo_tail_q;
  wire fifo_rdy = (fifo_cnt_q != 2'h2);
  wire push = push_v && fifo_rdy;
  wire pop = s_axis_tx_tvalid_q && s_axis_tx_tready;

  // State sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rx_acc && !m_axis_rx_tlast) begin
          state_d = req_ok ? ST_HDR1 : ST_DROP;
        end
      end
      // Reads need no data beat; 3-dword writes carry data here
      ST_HDR1: begin
        if (rx_acc) begin
          if (!ft_q[6]) begin
            state_d = ST_READ;
          end else if (ft_q[5]) begin
            state_d = ST_DATA;
          end else begin
            state_d = ST_WRITE;
          end
        end
      end
      // A 4-dword write with more than one data beat is drained
      ST_DATA: begin
        if (rx_acc) begin
          state_d = m_axis_rx_tlast ? ST_WRITE : ST_DROP;
        end
      end
      // Whole packet consumed, so the core never hangs on it
      ST_DROP: begin
        if (rx_acc && m_axis_rx_tlast) begin
          state_d = ST_IDLE;
        end
      end
      // One strobe cycle; the memory takes it on the next edge
      ST_WRITE: begin
        state_d = (ft_q == `PTM_FT_IOWR) ? ST_CPL0 : ST_IDLE;
      end
      // One cycle for the registered memory port
      ST_READ: begin
        state_d = ST_CPL0;
      end
      // Waits on a full buffer; receive stays stalled meanwhile
      ST_CPL0: begin
        if (fifo_rdy) begin
          state_d = ST_CPL1;
        end
      end
      ST_CPL1: begin
        if (fifo_rdy) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Ready only in states that take beats; low through writes and reads
  // Registered from the next state, so the stall starts on the edge that takes the last beat
  wire rx_take_d = (state_d == ST_IDLE) || (state_d == ST_HDR1) ||
                   (state_d == ST_DATA) || (state_d == ST_DROP);

  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      m_axis_rx_tready_q <= 1'b0;
      ft_q <= 7'h00;
      tc_q <= 3'h0;
      attr_q <= 2'h0;
      rid_q <= 16'h0000;
      tag_q <= 8'h00;
      be_q <= 4'h0;
      region_q <= 2'h0;
      addr_q <= {`PTM_ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      // Region memories are not cleared; undefined until written
    end else begin
      state_q <= state_d;
      m_axis_rx_tready_q <= rx_take_d;
      if (state_q == ST_IDLE && rx_acc) begin
        ft_q <= ft_in;
        tc_q <= dw0[22:20];
        attr_q <= dw0[13:12];
        rid_q <= dw1[31:16];
        tag_q <= dw1[15:8];
        be_q <= dw1[3:0];
        region_q <= region_in;
      end
      if (state_q == ST_HDR1 && rx_acc) begin
        // Low 11 bits only, so larger apertures alias
        if (ft_q[5]) begin
          addr_q <= m_axis_rx_tdata[32 +: `PTM_ADDR_W];
        end else begin
          addr_q <= m_axis_rx_tdata[0 +: `PTM_ADDR_W];
          wdata_q <= m_axis_rx_tdata[63:32];
        end
      end
      if (state_q == ST_DATA && rx_acc) begin
        wdata_q <= m_axis_rx_tdata[31:0];
      end
    end
  end

  // Region memories, one per region
  // Read port follows the held address; no read enable needed
  wire [31:0] rd_word [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : region_ram
      ptm_region_ram u_ram (
        .sys_clk(sys_clk),
        .wr_en((state_q == ST_WRITE) && (region_q == g)),
        .wr_addr(addr_q[10:2]),
        .wr_be(be_q),
        .wr_data(wdata_q),
        .rd_addr(addr_q[10:2]),
        .rd_data_q(rd_word[g])
      );
    end
  endgenerate

  // Byte count and lower address for a single dword
  // Only the first byte enables matter for one dword
  reg [11:0] byte_cnt;
  reg [1:0] low_bits;
  always @* begin
    casez (be_q)
      4'b1??1: byte_cnt = 12'h004;
      4'b01?1: byte_cnt = 12'h003;
      4'b1?10: byte_cnt = 12'h003;
      4'b0011: byte_cnt = 12'h002;
      4'b0110: byte_cnt = 12'h002;
      4'b1100: byte_cnt = 12'h002;
      default: byte_cnt = 12'h001;
    endcase
    casez (be_q)
      4'b???1: low_bits = 2'h0;
      4'b??10: low_bits = 2'h1;
      4'b?100: low_bits = 2'h2;
      4'b1000: low_bits = 2'h3;
      default: low_bits = 2'h0;
    endcase
  end

  // Completion header; IO write answers carry no data
  wire has_data = !ft_q[6];
  wire [6:0] cpl_ft = has_data ? `PTM_FT_CPLD : `PTM_FT_CPL;
  wire [9:0] cpl_len = has_data ? `PTM_LEN_ONE : 10'h000;
  wire [31:0] cpl_dw0 = {1'b0, cpl_ft, 1'b0, tc_q, 6'h00, attr_q, 2'h0, cpl_len};
  wire [31:0] cpl_dw1 = {cfg_completer_id, `PTM_CPL_SC, 1'b0, byte_cnt};
  wire [31:0] cpl_dw2 = {rid_q, tag_q, 1'b0, addr_q[6:2], low_bits};
  wire [7:0] keep1 = has_data ? `PTM_KEEP_ALL : `PTM_KEEP_LO;
  // Only completion words ever enter the buffer
  // Beat 1 takes read data straight from the registered port
  assign push_word = (state_q == ST_CPL0) ?
                     {1'b0, `PTM_KEEP_ALL, cpl_dw1, cpl_dw0} :
                     {1'b1, keep1, rd_word[region_q], cpl_dw2};

  // Push refused while full even with a pop due: shorter timing path
  wire [1:0] fifo_cnt_d = fifo_cnt_q + {1'b0, push} - {1'b0, pop};
  wire head_load = push && ((fifo_cnt_q == 2'h0) || (fifo_cnt_q == 2'h1 && pop));
  wire tail_load = push && ((fifo_cnt_q == 2'h1 && !pop) || (fifo_cnt_q == 2'h2 && pop));

  always @(posedge sys_clk) begin
    if (!resetn) begin
      fifo_cnt_q <= 2'h0;
      fifo_tail_q <= 73'h0;
      // Outputs low in reset so the core sees no stray beat
      s_axis_tx_tdata_q <= 64'h0000000000000000;
      s_axis_tx_tkeep_q <= 8'h00;
      s_axis_tx_tlast_q <= 1'b0;
      s_axis_tx_tvalid_q <= 1'b0;
    end else begin
      fifo_cnt_q <= fifo_cnt_d;
      s_axis_tx_tvalid_q <= (fifo_cnt_d != 2'h0);
      if (head_load) begin
        {s_axis_tx_tlast_q, s_axis_tx_tkeep_q, s_axis_tx_tdata_q} <= push_word;
      end else if (pop && fifo_cnt_q == 2'h2) begin
        {s_axis_tx_tlast_q, s_axis_tx_tkeep_q, s_axis_tx_tdata_q} <= fifo_tail_q;
      end
      if (tail_load) begin
        fifo_tail_q <= push_word;
      end
    end
  end
endmodule

// >>> verif/ptm_target_properties.sv
// Checker on the ports of ptm_target: completion framing and stream holds.
// Assumes one clock and the active-low synchronous reset of the target.
module ptm_target_chk (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Streams
  input wire m_axis_rx_tready_q,
  input wire [63:0] s_axis_tx_tdata_q,
  input wire [7:0] s_axis_tx_tkeep_q,
  input wire s_axis_tx_tlast_q,
  input wire s_axis_tx_tvalid_q,
  input wire s_axis_tx_tready,
  // Configuration
  input wire [15:0] cfg_completer_id
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // First completion beat on the wire
  wire hd = s_axis_tx_tvalid_q && !s_axis_tx_tlast_q;

  AST_TX_HOLD: assert property (s_axis_tx_tvalid_q && !s_axis_tx_tready |=>
    s_axis_tx_tvalid_q && $stable(s_axis_tx_tdata_q)) else $error("tx beat moved in stall");
  AST_CPL_ONLY: assert property (hd |-> s_axis_tx_tdata_q[30:24] == 7'h4A
    || s_axis_tx_tdata_q[30:24] == 7'h0A) else $error("non-completion sent");
  AST_CPL_ID: assert property (hd |-> s_axis_tx_tdata_q[63:48] == cfg_completer_id)
    else $error("completer id wrong");
  AST_STATUS: assert property (hd |-> s_axis_tx_tdata_q[47:45] == 3'h0)
    else $error("status not successful");
  AST_LEN: assert property (hd |-> s_axis_tx_tdata_q[9:0] == {9'h000,
    s_axis_tx_tdata_q[30]}) else $error("completion length wrong");
  AST_KEEP: assert property (hd |-> s_axis_tx_tkeep_q == 8'hFF)
    else $error("header beat keep wrong");
  AST_ORDER: assert property (hd && s_axis_tx_tready |=>
    s_axis_tx_tvalid_q && s_axis_tx_tlast_q) else $error("second beat missing");
  AST_RDY_LOW: assert property ($rose(s_axis_tx_tvalid_q) |->
    !$past(m_axis_rx_tready_q)) else $error("rx ready high before completion");
endmodule

bind ptm_target ptm_target_chk u_chk (.sys_clk, .resetn, .m_axis_rx_tready_q,
  .s_axis_tx_tdata_q, .s_axis_tx_tkeep_q, .s_axis_tx_tlast_q, .s_axis_tx_tvalid_q,
  .s_axis_tx_tready, .cfg_completer_id);

// >>> verif/ptm_core_model.sv
// Transmit side of the endpoint core: takes completions, stalls on request.
// Assumes one clock; the bench drives stall after a rising edge.
module ptm_core_model (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Completion stream
  input wire [63:0] tdata,
  input wire [7:0] tkeep,
  input wire tlast,
  input wire tvalid,
  output wire tready,
  // Bench side
  input wire stall,
  output logic [63:0] beat0,
  output logic [63:0] beat1,
  output logic [7:0] keep1,
  output int n_cpl
);
  timeunit 1ns;
  timeprecision 1ns;
  assign tready = !stall;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      n_cpl <= 0;
    end else if (tvalid && tready) begin
      if (tlast) begin
        beat1 <= tdata;
        keep1 <= tkeep;
        n_cpl <= n_cpl + 1;
      end else begin
        beat0 <= tdata;
      end
    end
  end
endmodule

// >>> verif/ptm_target_test.sv
// Self-checking bench for ptm_target with a core model on transmit.
// Assumes 50 MHz clock and synchronous active-low reset.
`include "ptm_map.vh"
module ptm_target_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [63:0] rx_data = 64'h0;
  logic [21:0] rx_user = 22'h0;
  logic rx_last = 1'b0;
  logic rx_valid = 1'b0;
  logic io_en = 1'b1;
  logic stall = 1'b0;
  logic [7:0] tag = 8'h00;
  wire rx_rdy, tx_last, tx_valid, tx_rdy;
  wire [63:0] tx_data, b0, b1;
  wire [7:0] tx_keep, kp1;
  int n_cpl;
  int n_errors = 0;
  int samples_checked = 0;
  localparam logic [15:0] CID = 16'h0123;
  localparam logic [15:0] RID = 16'hABCD;
  always #10 sys_clk = ~sys_clk;

  ptm_target u_dut (.sys_clk, .resetn, .m_axis_rx_tdata(rx_data), .m_axis_rx_tkeep(8'hFF),
    .m_axis_rx_tlast(rx_last), .m_axis_rx_tvalid(rx_valid), .m_axis_rx_tuser(rx_user),
    .m_axis_rx_tready_q(rx_rdy), .s_axis_tx_tdata_q(tx_data), .s_axis_tx_tkeep_q(tx_keep),
    .s_axis_tx_tlast_q(tx_last), .s_axis_tx_tvalid_q(tx_valid), .s_axis_tx_tready(tx_rdy),
    .cfg_completer_id(CID), .io_bar_enable(io_en));
  ptm_core_model u_core (.sys_clk, .resetn, .tdata(tx_data), .tkeep(tx_keep), .tlast(tx_last),
    .tvalid(tx_valid), .tready(tx_rdy), .stall, .beat0(b0), .beat1(b1), .keep1(kp1), .n_cpl);

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tmo(input string m);
    n_errors++;
    $display("CHECK FAILED %0t no answer on %s", $time, m);
    end_sim();
  endtask

  // Entered just after a rising edge; holds each beat until taken
  task automatic send(input logic [7:0] hit, input logic [63:0] bt[3], input int nb);
    int k;
    for (int i = 0; i < nb; i++) begin
      rx_valid <= 1'b1;
      rx_data <= bt[i];
      rx_last <= (i == nb - 1);
      rx_user <= {12'h000, hit, 2'b00};
      k = 0;
      do begin
        @(negedge sys_clk);
        k++;
      end while (rx_rdy !== 1'b1 && k < 100);
      if (rx_rdy !== 1'b1) tmo("rx");
      @(posedge sys_clk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask

  // kind: 0 no completion, 1 completion without data, 2 with data
  task automatic req(input logic [7:0] hit, input logic [6:0] ft, input logic [31:0] a,
      input logic [31:0] d, input logic [9:0] len, input int kind);
    logic [63:0] bt[3];
    logic [31:0] h0;
    int c;
    int k;
    h0 = {1'b0, ft, 8'h50, 4'h2, 2'b00, len};
    tag++;
    bt[0] = {RID, tag, 8'h0F, h0};
    bt[1] = ft[5] ? {a, 32'h0} : {d, a};
    bt[2] = {~d, d};
    c = n_cpl;
    send(hit, bt, (ft[6] && (ft[5] || len != 10'h001)) ? 3 : 2);
    if (kind == 0) begin
      repeat (30) @(posedge sys_clk);
      chk(n_cpl, c, "unexpected completion");
      return;
    end
    k = 0;
    while (n_cpl == c && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    if (n_cpl == c) tmo("tx");
    h0 = {1'b0, kind == 2 ? `PTM_FT_CPLD : `PTM_FT_CPL, 8'h50, 4'h2, 3'h0, 8'h00, kind == 2};
    chk(b0, {CID, 3'h0, 1'b0, 12'h004, h0}, "cpl header");
    chk(b1[31:0], {RID, tag, 1'b0, a[6:2], 2'b00}, "cpl requester");
    chk(kp1, (kind == 2) ? `PTM_KEEP_ALL : `PTM_KEEP_LO, "cpl last keep");
    if (kind == 2) chk(b1[63:32], d, "read data");
  endtask

  task automatic t_regions;
    logic [7:0] hit[4] = '{`PTM_HIT_MEM32, `PTM_HIT_MEM64, `PTM_HIT_EXPROM, `PTM_HIT_IO};
    logic [6:0] wft[4] = '{`PTM_FT_MWR32, `PTM_FT_MWR64, `PTM_FT_MWR32, `PTM_FT_IOWR};
    logic [6:0] rft[4] = '{`PTM_FT_MRD32, `PTM_FT_MRD64, `PTM_FT_MRD32, `PTM_FT_IORD};
    for (int i = 0; i < 4; i++)
      req(hit[i], wft[i], 32'h24, 32'hC0DE0000 + i, 10'h001, i == 3);
    for (int i = 0; i < 4; i++)
      req(hit[i], rft[i], 32'h24, 32'hC0DE0000 + i, 10'h001, 2);
  endtask

  task automatic t_alias;
    req(`PTM_HIT_MEM32, `PTM_FT_MWR32, 32'h7FC, 32'h5A5AA5A5, 10'h001, 0);
    req(`PTM_HIT_MEM32, `PTM_FT_MRD32, 32'h1FFC, 32'h5A5AA5A5, 10'h001, 2);
  endtask

  task automatic t_drop;
    req(`PTM_HIT_MEM32, `PTM_FT_MWR32, 32'h24, 32'hDEAD0001, 10'h002, 0);
    req(8'h06, `PTM_FT_MWR32, 32'h24, 32'hDEAD0002, 10'h001, 0);
    io_en <= 1'b0;
    req(`PTM_HIT_IO, `PTM_FT_IORD, 32'h24, 32'h0, 10'h001, 0);
    io_en <= 1'b1;
    req(`PTM_HIT_MEM32, `PTM_FT_MRD32, 32'h24, 32'hC0DE0000, 10'h001, 2);
  endtask

  // Core refuses completions for a while; nothing may be lost
  task automatic t_stall;
    stall <= 1'b1;
    fork
      begin
        repeat (60) @(posedge sys_clk);
        stall <= 1'b0;
      end
    join_none
    req(`PTM_HIT_MEM64, `PTM_FT_MRD64, 32'h24, 32'hC0DE0001, 10'h001, 2);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_regions();
    t_alias();
    t_drop();
    t_stall();
    end_sim();
  end
endmodule
